// ==== test/endpoint_sink.sv ====
// Purpose: Endpoint that accepts responses
// Assumes: Same clock as issuer
// Notes:   Slow mode stalls
`timescale 1ns/1ps
`default_nettype none
module endpoint_sink (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_slow,
	input wire logic i_msg_valid,
	output logic     o_msg_ready
);
	logic ready_q, ready_d;
	// Every response is taken, slow mode every other cycle
	always_comb ready_d = i_slow ? i_msg_valid && !ready_q : 1'b1;
	always_ff @(posedge i_mclk) ready_q <= i_sys_rst ? 1'b0 : ready_d;
	assign o_msg_ready = ready_q;
endmodule // endpoint_sink
`default_nettype wire

// ==== test/pfri_monitor.sv ====
// Purpose: Port checker for the issuer
// Assumes: One clock, sync reset
// Notes:   Bind at foot
`timescale 1ns/1ps
`default_nettype none
module pfri_monitor (
	input wire logic         i_mclk,
	input wire logic         i_sys_rst,
	input wire logic         i_cmd_valid,
	input wire logic [127:0] i_cmd_desc,
	input wire logic         o_cmd_ready,
	input wire logic         o_msg_valid,
	input wire logic         i_msg_ready,
	input wire logic         o_msg_kind,
	input wire logic [15:0]  o_msg_req_id,
	input wire logic         o_msg_pasid_present,
	input wire logic [8:0]   o_msg_group_index,
	input wire logic [3:0]   o_msg_code
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	// Take of a response type
	logic take, good;
	assign take = i_cmd_valid && o_cmd_ready;
	assign good = i_cmd_desc[3:1] == 3'h4;
	sequence took; take && good; endsequence
	sequence held; o_msg_valid && !i_msg_ready; endsequence
	a_take_gives_msg: assert property (took |=> o_msg_valid)
		else $error("no message after take");
	a_bad_type_dropped: assert property (take && !good |=> !o_msg_valid)
		else $error("message from bad type");
	a_kind_decode: assert property (took |=> o_msg_kind != $past(i_cmd_desc[0]))
		else $error("kind wrong");
	a_req_id_copy: assert property (took |=> o_msg_req_id == $past(i_cmd_desc[33:18]))
		else $error("req id wrong");
	a_code_copy: assert property (took |=> o_msg_code == $past(i_cmd_desc[8:5]))
		else $error("code wrong");
	a_group_index: assert property (took |=> o_msg_group_index == $past(i_cmd_desc[17:9]))
		else $error("group index wrong");
	a_stream_pasid: assert property (o_msg_valid && o_msg_kind |-> o_msg_pasid_present)
		else $error("stream lacks pasid");
	a_msg_held: assert property (held |=> o_msg_valid && $stable(o_msg_code) && !o_cmd_ready)
		else $error("message not held");
endmodule // pfri_monitor
bind page_fault_response_issuer pfri_monitor mon (
	.i_mclk              (i_mclk),
	.i_sys_rst           (i_sys_rst),
	.i_cmd_valid         (i_cmd_valid),
	.i_cmd_desc          (i_cmd_desc),
	.o_cmd_ready         (o_cmd_ready),
	.o_msg_valid         (o_msg_valid),
	.i_msg_ready         (i_msg_ready),
	.o_msg_kind          (o_msg_kind),
	.o_msg_req_id        (o_msg_req_id),
	.o_msg_pasid_present (o_msg_pasid_present),
	.o_msg_group_index   (o_msg_group_index),
	.o_msg_code          (o_msg_code)
);
`default_nettype wire

// ==== test/test_page_fault_response_issuer.sv ====
// Purpose: Self-checking bench
// Assumes: 40 MHz clock
// Notes:   Queue model per message
`timescale 1ns/1ps
`default_nettype none
module test_page_fault_response_issuer;
	logic         i_mclk, i_sys_rst, i_cmd_valid, i_avs_read, i_avs_write, slow;
	logic [127:0] i_cmd_desc, d;
	logic [4:0]   i_avs_address;
	logic [31:0]  i_avs_writedata, rd;
	logic [3:0]   i_avs_byteenable;
	wire          o_cmd_ready, o_msg_valid, i_msg_ready, o_msg_kind, o_msg_pasid_present, o_avs_waitrequest;
	wire [15:0]   o_msg_req_id;
	wire [19:0]   o_msg_pasid;
	wire [51:0]   o_msg_addr;
	wire [8:0]    o_msg_group_index;
	wire [3:0]    o_msg_code;
	wire [21:0]   o_msg_priv;
	wire [31:0]   o_avs_readdata;
	logic [124:0] q[$];
	int           n_mismatch, checks_done, seed, ng, ns, nb, n;
	logic [3:0]   tys[4] = '{4'h9, 4'h8, 4'h3, 4'h9};
	logic [3:0]   cds[5] = '{4'h0, 4'h1, 4'hF, 4'h7, 4'hE};
	page_fault_response_issuer uut (
		.i_mclk              (i_mclk),
		.i_sys_rst           (i_sys_rst),
		.i_cmd_valid         (i_cmd_valid),
		.i_cmd_desc          (i_cmd_desc),
		.o_cmd_ready         (o_cmd_ready),
		.o_msg_valid         (o_msg_valid),
		.i_msg_ready         (i_msg_ready),
		.o_msg_kind          (o_msg_kind),
		.o_msg_req_id        (o_msg_req_id),
		.o_msg_pasid_present (o_msg_pasid_present),
		.o_msg_pasid         (o_msg_pasid),
		.o_msg_addr          (o_msg_addr),
		.o_msg_group_index   (o_msg_group_index),
		.o_msg_code          (o_msg_code),
		.o_msg_priv          (o_msg_priv),
		.i_avs_address       (i_avs_address),
		.i_avs_read          (i_avs_read),
		.i_avs_write         (i_avs_write),
		.i_avs_writedata     (i_avs_writedata),
		.i_avs_byteenable    (i_avs_byteenable),
		.o_avs_readdata      (o_avs_readdata),
		.o_avs_waitrequest   (o_avs_waitrequest)
	);
	endpoint_sink ep (.i_mclk, .i_sys_rst, .i_slow(slow), .i_msg_valid(o_msg_valid), .o_msg_ready(i_msg_ready));
	initial begin
		i_mclk = 0;
		forever #12.5 i_mclk = ~i_mclk;
	end
	task complete_run;
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string nm, input logic [124:0] e, input logic [124:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	// Expected message from a descriptor, one field a line
	function logic [124:0] model(input logic [127:0] x);
		model[124]     = x[3:0] == 4'h8;
		model[123:108] = x[33:18];
		model[107]     = x[3:0] == 4'h8 || x[4];
		model[106:87]  = x[53:34];
		model[86:35]   = x[127:76];
		model[34:26]   = x[17:9];
		model[25:22]   = x[8:5];
		model[21:0]    = x[75:54];
	endfunction
	// Every accepted message against the queue
	always @(posedge i_mclk) if (o_msg_valid === 1'b1 && i_msg_ready === 1'b1)
		chk("msg", q.size() ? q.pop_front() : 'x, {o_msg_kind, o_msg_req_id, o_msg_pasid_present, o_msg_pasid,
			o_msg_addr, o_msg_group_index, o_msg_code, o_msg_priv});
	task av(input logic w, input logic [4:0] a, input logic [31:0] x, input logic [3:0] be);
		@(posedge i_mclk);
		i_avs_read <= !w;
		i_avs_write <= w;
		i_avs_address <= a;
		i_avs_writedata <= x;
		i_avs_byteenable <= be;
		// No cycle count assumed; only the watchdog ends a stuck wait
		do begin
			@(posedge i_mclk);
		end while (o_avs_waitrequest !== 1'b0);
		rd = o_avs_readdata;
		i_avs_read <= 0;
		i_avs_write <= 0;
	endtask
	task send(input logic [127:0] x);
		@(posedge i_mclk);
		i_cmd_valid <= 1;
		i_cmd_desc <= x;
		do begin
			@(posedge i_mclk);
		end while (o_cmd_ready !== 1'b1);
		i_cmd_valid <= 0;
		if (x[3:1] == 3'h4)
			q.push_back(model(x));
		ng += x[3:0] == 4'h9;
		ns += x[3:0] == 4'h8;
		nb += x[3:1] != 3'h4;
	endtask
	// Hang guard
	initial begin
		#500000;
		n_mismatch++;
		complete_run;
	end
	initial begin
		seed = 33545;
		{i_sys_rst, i_cmd_valid, i_avs_read, i_avs_write, slow} <= 5'h10;
		{i_cmd_desc, i_avs_address, i_avs_writedata, i_avs_byteenable} <= '0;
		repeat (12) @(posedge i_mclk);
		i_sys_rst <= 0;
		av(1, 5'h14, 32'hFFFF_FFFF, 4'hF);
		for (int k = 0; k < 6; k++) begin
			av(0, 5'(k * 4), 32'h0000_0000, 4'hF);
			chk("reset reg", 0, rd);
		end
		av(1, 5'h00, 32'h0000_0001, 4'hF);
		for (int i = 0; i < 20; i++) begin
			slow <= i[2];
			d = {$random(seed), $random(seed), $random(seed), $random(seed)};
			d[3:0] = tys[i % 4];
			d[8:5] = cds[i % 5];
			if (i == 0)
				d[17:9] = 9'h1FF;
			send(d);
		end
		for (n = 0; q.size() > 0 && n < 100; n++) @(posedge i_mclk);
		av(0, 5'h08, 32'h0000_0000, 4'hF);
		chk("groups", ng, rd);
		av(0, 5'h0C, 32'h0000_0000, 4'hF);
		chk("streams", ns, rd);
		av(0, 5'h10, 32'h0000_0000, 4'hF);
		chk("bad", nb, rd);
		av(0, 5'h04, 32'h0000_0000, 4'hF);
		chk("status", 32'h0000_0002, rd);
		av(1, 5'h04, 32'h0000_0002, 4'hF);
		av(0, 5'h04, 32'h0000_0000, 4'hF);
		chk("status clr", 0, rd);
		av(1, 5'h00, 32'h0000_0000, 4'h0);
		av(0, 5'h00, 32'h0000_0000, 4'hF);
		chk("ctrl kept", 1, rd);
		av(1, 5'h00, 32'h0000_0000, 4'hF);
		// Ready still stands one edge after the disabling write lands
		@(posedge i_mclk);
		i_cmd_valid <= 1;
		repeat (6) @(posedge i_mclk);
		chk("ready off", 0, o_cmd_ready);
		chk("left", 0, q.size());
		complete_run;
	end
endmodule // test_page_fault_response_issuer
`default_nettype wire

// ==== verilog/page_fault_response_issuer.sv ====
// Purpose: Turns page response descriptors into page response messages
// Assumes: Descriptor source and message sink run on i_mclk
// Notes:   One message in flight; registers on Avalon-MM with waitrequest
`timescale 1ns/1ps
`default_nettype none
module page_fault_response_issuer (
	input  wire logic         i_mclk,
	input  wire logic         i_sys_rst,
	// Command queue descriptor stream
	input  wire logic         i_cmd_valid,
	input  wire logic [127:0] i_cmd_desc,
	output logic              o_cmd_ready,
	// Outgoing response message
	output logic              o_msg_valid,
	input  wire logic         i_msg_ready,
	output logic              o_msg_kind,
	output logic [15:0]       o_msg_req_id,
	output logic              o_msg_pasid_present,
	output logic [19:0]       o_msg_pasid,
	output logic [51:0]       o_msg_addr,
	output logic [8:0]        o_msg_group_index,
	output logic [3:0]        o_msg_code,
	output logic [21:0]       o_msg_priv,
	// Avalon-MM slave
	input  wire logic [4:0]   i_avs_address,
	input  wire logic         i_avs_read,
	input  wire logic         i_avs_write,
	input  wire logic [31:0]  i_avs_writedata,
	input  wire logic [3:0]   i_avs_byteenable,
	output logic [31:0]       o_avs_readdata,
	output logic              o_avs_waitrequest
);
	// Bus state
	logic        wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;
	logic        en_q, en_d;
	logic        bus_wr;
	// Engine state
	page_resp_pkg::state_type state_q, state_d;
	logic        rdy_q, rdy_d;
	logic        mv_q, mv_d;
	logic        kind_q, kind_d;
	logic [15:0] rid_q, rid_d;
	logic        pp_q, pp_d;
	logic [19:0] pasid_q, pasid_d;
	logic [51:0] addr_q, addr_d;
	logic [8:0]  gidx_q, gidx_d;
	logic [3:0]  code_q, code_d;
	logic [21:0] priv_q, priv_d;
	logic [31:0] grp_cnt_q, grp_cnt_d;
	logic [31:0] strm_cnt_q, strm_cnt_d;
	logic [31:0] bad_cnt_q, bad_cnt_d;
	logic        bad_q, bad_d;
	logic        take;
	logic [3:0]  dtype;

	// Write lands only on the cycle waitrequest is low
	assign bus_wr = i_avs_write & ~wait_q;
	assign take   = i_cmd_valid & rdy_q;
	assign dtype  = i_cmd_desc[page_resp_pkg::TYPE_LSB +: page_resp_pkg::TYPE_W];

	// Bus slave: one wait cycle, then a one-cycle answer
	always_comb begin
		wait_d  = 1'b1;
		rdata_d = rdata_q;
		en_d    = en_q;
		if ((i_avs_read | i_avs_write) & wait_q) begin
			wait_d  = 1'b0;
			rdata_d = page_resp_pkg::RD_ZERO; // Unmapped reads give zero
			case (i_avs_address)
				page_resp_pkg::REG_CTRL: begin
					rdata_d[page_resp_pkg::CTRL_EN_BIT] = en_q;
				end
				page_resp_pkg::REG_STATUS: begin
					rdata_d[page_resp_pkg::STAT_BUSY_BIT] = state_q == page_resp_pkg::ST_SEND;
					rdata_d[page_resp_pkg::STAT_BAD_BIT]  = bad_q;
				end
				page_resp_pkg::REG_GRP_CNT: begin
					rdata_d = grp_cnt_q;
				end
				page_resp_pkg::REG_STRM_CNT: begin
					rdata_d = strm_cnt_q;
				end
				page_resp_pkg::REG_BAD_CNT: begin
					rdata_d = bad_cnt_q;
				end
				default: begin
					rdata_d = page_resp_pkg::RD_ZERO;
				end
			endcase
		end
		if (bus_wr && i_avs_address == page_resp_pkg::REG_CTRL && i_avs_byteenable[0]) begin
			en_d = i_avs_writedata[page_resp_pkg::CTRL_EN_BIT];
		end
	end

	// Bus registers
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			wait_q  <= 1'b1;
			rdata_q <= page_resp_pkg::RD_ZERO;
			en_q    <= page_resp_pkg::CTRL_EN_RESET;
		end else begin
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
			en_q    <= en_d;
		end
	end

	// Engine: take a descriptor, decode, hold message until sink accepts
	always_comb begin
		state_d    = state_q;
		mv_d       = mv_q;
		kind_d     = kind_q;
		rid_d      = rid_q;
		pp_d       = pp_q;
		pasid_d    = pasid_q;
		addr_d     = addr_q;
		gidx_d     = gidx_q;
		code_d     = code_q;
		priv_d     = priv_q;
		grp_cnt_d  = grp_cnt_q;
		strm_cnt_d = strm_cnt_q;
		bad_cnt_d  = bad_cnt_q;
		bad_d      = bad_q;
		// Write-one-to-clear of the bad type flag; a new event below wins
		if (bus_wr && i_avs_address == page_resp_pkg::REG_STATUS && i_avs_byteenable[0]
			&& i_avs_writedata[page_resp_pkg::STAT_BAD_BIT]) begin
			bad_d = 1'b0;
		end
		case (state_q)
			page_resp_pkg::ST_IDLE: begin
				if (take) begin
					// Fields copied verbatim; software owns their correctness
					rid_d   = i_cmd_desc[page_resp_pkg::RID_LSB +: page_resp_pkg::RID_W];
					pasid_d = i_cmd_desc[page_resp_pkg::PASID_LSB +: page_resp_pkg::PASID_W];
					addr_d  = i_cmd_desc[page_resp_pkg::ADDR_LSB +: page_resp_pkg::ADDR_W];
					gidx_d  = i_cmd_desc[page_resp_pkg::GIDX_LSB +: page_resp_pkg::GIDX_W];
					code_d  = i_cmd_desc[page_resp_pkg::CODE_LSB +: page_resp_pkg::CODE_W];
					priv_d  = i_cmd_desc[page_resp_pkg::PRIV_LSB +: page_resp_pkg::PRIV_W];
					if (dtype == page_resp_pkg::TYPE_GROUP_RESP) begin
						kind_d    = page_resp_pkg::KIND_GROUP;
						pp_d      = i_cmd_desc[page_resp_pkg::PP_BIT];
						grp_cnt_d = grp_cnt_q + page_resp_pkg::CNT_ONE;
						mv_d      = 1'b1;
						state_d   = page_resp_pkg::ST_SEND;
					end else if (dtype == page_resp_pkg::TYPE_STREAM_RESP) begin
						kind_d     = page_resp_pkg::KIND_STREAM;
						pp_d       = 1'b1; // Stream replies always carry a PASID
						strm_cnt_d = strm_cnt_q + page_resp_pkg::CNT_ONE;
						mv_d       = 1'b1;
						state_d    = page_resp_pkg::ST_SEND;
					end else begin
						// Other descriptor kinds belong elsewhere; count and drop
						bad_cnt_d = bad_cnt_q + page_resp_pkg::CNT_ONE;
						bad_d     = 1'b1;
					end
				end
			end
			page_resp_pkg::ST_SEND: begin
				if (i_msg_ready) begin
					mv_d    = 1'b0;
					state_d = page_resp_pkg::ST_IDLE;
				end
			end
			default: begin
				mv_d    = 1'b0;
				state_d = page_resp_pkg::ST_IDLE;
			end
		endcase
		// Ready only in idle; disabling stalls the queue, never drops
		rdy_d = en_q && state_d == page_resp_pkg::ST_IDLE && !take;
	end

	// Engine registers
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			state_q    <= page_resp_pkg::ST_IDLE;
			rdy_q      <= 1'b0;
			mv_q       <= 1'b0;
			kind_q     <= page_resp_pkg::KIND_GROUP;
			rid_q      <= '0;
			pp_q       <= 1'b0;
			pasid_q    <= '0;
			addr_q     <= '0;
			gidx_q     <= '0;
			code_q     <= page_resp_pkg::CODE_SUCCESS;
			priv_q     <= '0;
			grp_cnt_q  <= page_resp_pkg::CNT_RESET;
			strm_cnt_q <= page_resp_pkg::CNT_RESET;
			bad_cnt_q  <= page_resp_pkg::CNT_RESET;
			bad_q      <= 1'b0;
		end else begin
			state_q    <= state_d;
			rdy_q      <= rdy_d;
			mv_q       <= mv_d;
			kind_q     <= kind_d;
			rid_q      <= rid_d;
			pp_q       <= pp_d;
			pasid_q    <= pasid_d;
			addr_q     <= addr_d;
			gidx_q     <= gidx_d;
			code_q     <= code_d;
			priv_q     <= priv_d;
			grp_cnt_q  <= grp_cnt_d;
			strm_cnt_q <= strm_cnt_d;
			bad_cnt_q  <= bad_cnt_d;
			bad_q      <= bad_d;
		end
	end

	// Outputs straight from flops
	assign o_cmd_ready         = rdy_q;
	assign o_msg_valid         = mv_q;
	assign o_msg_kind          = kind_q;
	assign o_msg_req_id        = rid_q;
	assign o_msg_pasid_present = pp_q;
	assign o_msg_pasid         = pasid_q;
	assign o_msg_addr          = addr_q;
	assign o_msg_group_index   = gidx_q;
	assign o_msg_code          = code_q;
	assign o_msg_priv          = priv_q;
	assign o_avs_readdata      = rdata_q;
	assign o_avs_waitrequest   = wait_q;
endmodule // page_fault_response_issuer
`default_nettype wire

// ==== verilog/page_resp_pkg.sv ====
// Purpose: Shared constants for the page response issuer
// Assumes: 128-bit command descriptors, 32-bit Avalon-MM register bus
// Notes:   Descriptor field positions and type codes are fixed here for the design; the monitor and bench repeat them as literals
`default_nettype none
package page_resp_pkg;
	// Descriptor geometry
	localparam int DESC_W        = 128;
	localparam int TYPE_LSB      = 0;
	localparam int TYPE_W        = 4;
	localparam int PP_BIT        = 4;
	localparam int CODE_LSB      = 5;
	localparam int CODE_W        = 4;
	localparam int GIDX_LSB      = 9;
	localparam int GIDX_W        = 9;
	localparam int RID_LSB       = 18;
	localparam int RID_W         = 16;
	localparam int BUS_W         = 8;
	localparam int PASID_LSB     = 34;
	localparam int PASID_W       = 20;
	localparam int PRIV_LSB      = 54;
	localparam int PRIV_W        = 22;
	localparam int ADDR_LSB      = 76;
	localparam int ADDR_W        = 52;

	// Descriptor type codes, values arbitrary
	localparam logic [3:0] TYPE_GROUP_RESP  = 4'h9;
	localparam logic [3:0] TYPE_STREAM_RESP = 4'h8;

	// Response codes
	localparam logic [3:0] CODE_SUCCESS = 4'h0;
	localparam logic [3:0] CODE_INVALID = 4'h1;
	localparam logic [3:0] CODE_FAILURE = 4'hF;

	// Message kinds on the link
	localparam logic KIND_GROUP  = 1'b0;
	localparam logic KIND_STREAM = 1'b1;

	// Register byte addresses
	localparam int          ADDR_BITS    = 5;
	localparam logic [4:0]  REG_CTRL     = 5'h00;
	localparam logic [4:0]  REG_STATUS   = 5'h04;
	localparam logic [4:0]  REG_GRP_CNT  = 5'h08;
	localparam logic [4:0]  REG_STRM_CNT = 5'h0C;
	localparam logic [4:0]  REG_BAD_CNT  = 5'h10;

	// Register fields and reset values
	localparam int          CTRL_EN_BIT    = 0;
	localparam int          STAT_BUSY_BIT  = 0;
	localparam int          STAT_BAD_BIT   = 1;
	localparam logic        CTRL_EN_RESET  = 1'b0;
	localparam logic [31:0] CNT_RESET      = 32'h0000_0000;
	localparam logic [31:0] CNT_ONE        = 32'h0000_0001;
	localparam logic [31:0] RD_ZERO        = 32'h0000_0000;

	// Engine states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} state_type;
endpackage
`default_nettype wire
